// file: reg_file_model.sv
`timescale 1ns/100ps
module reg_file_model (
    input  wire logic       sys_clk, rd_en, rd_bank, wr_en, wr_bank,
    input  wire logic [7:0] rd_addr, wr_addr, wr_data,
    output logic [7:0]      rd_data
);
    logic [7:0] mem [512];
    logic       tog = 1'b0;
    // Idle bus toggles so a late sample shows up
    assign rd_data = rd_en ? mem[{rd_bank, rd_addr}] : {8{tog}};
    initial for (int i = 0; i < 512; i++) mem[i] = i[7:0] ^ 8'hd7;
    always @(posedge sys_clk) begin
        tog <= !tog;
        if (wr_en) mem[{wr_bank, wr_addr}] <= wr_data;
    end
endmodule

// file: rot_set_chk.sv
`timescale 1ns/100ps
module rot_set_chk (
    input wire logic        sys_clk, arst_n, instr_valid, ext_set_en, busy_q, done_q,
    input wire logic [15:0] instr,
    input wire logic        rd_en_q, rd_bank_sel_q, rd_indexed_q, wr_en_q, acc_wr_q, flag_wr_q, neg_q, zero_q,
    input wire logic [7:0]  rd_addr_q, rd_data, wr_data_q, acc_data_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    logic [15:0] i_q;
    logic [7:0]  v_q;
    wire take = !busy_q && instr_valid && (instr[15:10] == 6'h10 || instr[15:9] == 7'h34);
    always @(posedge sys_clk) begin
        if (take) i_q <= instr;
        if (rd_en_q) v_q <= rd_data;
    end
    sequence quarters_s;
        rd_en_q && busy_q ##1 (busy_q && !rd_en_q)[*2] ##1 (done_q && !busy_q);
    endsequence
    op_timing_a: assert property (take |=> quarters_s) else $error("op timing");
    busy_refuse_a: assert property (busy_q |=> !rd_en_q) else $error("taken while busy");
    rot_data_a: assert property (flag_wr_q |-> (wr_en_q ? wr_data_q : acc_data_q) == {v_q[0], v_q[7:1]})
        else $error("rotate result");
    rot_flags_a: assert property (flag_wr_q |-> neg_q == v_q[0] && zero_q == (v_q == 8'h00))
        else $error("flags");
    rot_dest_a: assert property (flag_wr_q |-> wr_en_q == i_q[9] && acc_wr_q == !i_q[9]) else $error("dest");
    set_ones_a: assert property (done_q && i_q[15:9] == 7'h34 |-> wr_en_q && wr_data_q == 8'hff && !flag_wr_q)
        else $error("set");
    rd_bank_a: assert property (rd_en_q |-> rd_addr_q == i_q[7:0] && rd_bank_sel_q == i_q[8]) else $error("bank");
    indexed_a: assert property (rd_en_q |-> rd_indexed_q == (!i_q[8] && ext_set_en && i_q[7:0] <= 8'h5f))
        else $error("indexed");
endmodule

// file: rot_set_decode.v
`timescale 1ns/100ps
`include "rot_set_regs.vh"

module rot_set_decode (
    // Instruction
    input  wire [15:0] instr,
    input  wire        ext_set_en,
    // Decoded fields
    output wire        is_rotate,
    output wire        is_set,
    output wire        dest_file,
    output wire        use_bank_reg,
    output wire        indexed_mode,
    output wire [7:0]  file_addr
);
    assign is_rotate    = (instr[`ROR_OPC_MSB:`ROR_OPC_LSB] == `ROR_OPC); // RL1
    assign is_set       = (instr[`SET_OPC_MSB:`SET_OPC_LSB] == `SET_OPC); // RL11
    assign dest_file    = instr[`FLD_DEST]; // RL3
    assign use_bank_reg = instr[`FLD_ACC]; // RL5 RL9
    assign file_addr    = instr[`FLD_ADDR_MSB:`FLD_ADDR_LSB];
    assign indexed_mode = ~instr[`FLD_ACC] & ext_set_en & (file_addr <= `IDX_LIMIT); // RL6
endmodule

// file: rot_set_exec.v
`timescale 1ns/100ps
`include "rot_set_regs.vh"

// Summary of operation
// RL1: The rotate is decoded from the fixed upper pattern, destination bit, access bit and 8-bit address.
// RL2: The rotate moves every bit one place lower and puts the old bit 0 into bit 7, ignoring carry.
// RL3: A destination bit of 0 sends the rotate result to the accumulator, 1 back to the file register.
// RL4: The rotate updates only the negative and zero flags from its result.
// RL5: For the rotate, access bit 0 picks the access bank and 1 picks the bank-select register's bank.
// RL6: Indexed literal-offset addressing applies when access is 0, extended set is on and address is at most 95.
// RL7: Each instruction is one word and finishes in one instruction cycle.
// RL8: The set instruction writes all ones into the addressed file register.
// RL9: For the set, access bit 0 picks the access bank and 1 the general-purpose bank from the bank-select register.
// RL10: Quarters are decode, read, process and write, in that order.
// RL11: The set is decoded from pattern 0110 100, access bit and address, and touches no flag.
module rot_set_exec (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        arst_n,
    // Decoder side
    input  wire        instr_valid,
    input  wire [15:0] instr,
    input  wire        ext_set_en,
    output reg         busy_q,
    output reg         done_q,
    // Register file read
    output reg         rd_en_q,
    output reg  [7:0]  rd_addr_q,
    output reg         rd_bank_sel_q,
    output reg         rd_indexed_q,
    input  wire [7:0]  rd_data,
    // Register file write
    output reg         wr_en_q,
    output reg  [7:0]  wr_addr_q,
    output reg         wr_bank_sel_q,
    output reg         wr_indexed_q,
    output reg  [7:0]  wr_data_q,
    // Accumulator write
    output reg         acc_wr_q,
    output reg  [7:0]  acc_data_q,
    // Status flags
    output reg         flag_wr_q,
    output reg         neg_q,
    output reg         zero_q
);
    wire       dec_rot;
    wire       dec_set;
    wire       dec_dest;
    wire       dec_bank;
    wire       dec_idx;
    wire [7:0] dec_addr;
    // Quarter qualifiers and the rotated byte
    wire       accept;
    wire       in_write;
    wire [7:0] rot_val;

    reg  [3:0] q_state_q;
    reg  [3:0] q_state_d;
    reg        op_rot_q;
    reg        op_set_q;
    reg        dest_q;
    reg  [7:0] result_q;

    // One-hot quarter states
    localparam [3:0] ST_DECODE  = `Q1_ST;
    localparam [3:0] ST_READ    = `Q2_ST;
    localparam [3:0] ST_PROCESS = `Q3_ST;
    localparam [3:0] ST_WRITE   = `Q4_ST;

    rot_set_decode u_dec (
        .instr        (instr),
        .ext_set_en   (ext_set_en),
        .is_rotate    (dec_rot),
        .is_set       (dec_set),
        .dest_file    (dec_dest),
        .use_bank_reg (dec_bank),
        .indexed_mode (dec_idx),
        .file_addr    (dec_addr)
    );

    // Only an idle decode quarter takes a word; a word seen while busy is dropped
    assign accept   = (q_state_q == ST_DECODE) && instr_valid && (dec_rot || dec_set); // RL1 RL11
    assign in_write = (q_state_q == ST_WRITE);
    // Carry is no input here; bit 0 wraps round to bit 7
    assign rot_val  = {result_q[0], result_q[7:1]}; // RL2

    // Four quarters make one instruction cycle
    always @* begin
        case (q_state_q)
            ST_DECODE:  q_state_d = accept ? ST_READ : ST_DECODE; // RL10
            ST_READ:    q_state_d = ST_PROCESS;
            ST_PROCESS: q_state_d = ST_WRITE;
            ST_WRITE:   q_state_d = ST_DECODE; // RL7
            default:    q_state_d = ST_DECODE;
        endcase
    end

    // Quarter register
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            q_state_q <= ST_DECODE;
        end else begin
            q_state_q <= q_state_d;
        end
    end

    // Busy from acceptance to the write quarter, done for the cycle after it
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            busy_q <= accept || (q_state_q == ST_READ) || (q_state_q == ST_PROCESS); // RL10
            done_q <= in_write; // RL7
        end
    end

    // Operation kind and destination held for the rest of the cycle
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            op_rot_q <= 1'b0;
            op_set_q <= 1'b0;
            dest_q   <= 1'b0;
        end else if (accept) begin
            op_rot_q <= dec_rot; // RL1
            op_set_q <= dec_set; // RL11
            // The set has no destination bit and always writes the file
            dest_q   <= dec_rot ? dec_dest : 1'b1; // RL3
        end
    end

    // Read strobe for the read quarter; address and bank hold afterwards
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_en_q       <= 1'b0;
            rd_addr_q     <= `BYTE_RST;
            rd_bank_sel_q <= 1'b0;
            rd_indexed_q  <= 1'b0;
        end else begin
            rd_en_q <= accept;
            if (accept) begin
                rd_addr_q     <= dec_addr;
                rd_bank_sel_q <= dec_bank; // RL5 RL9
                rd_indexed_q  <= dec_idx; // RL6
            end
        end
    end

    // Write target is the same file location as the read
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_addr_q     <= `BYTE_RST;
            wr_bank_sel_q <= 1'b0;
            wr_indexed_q  <= 1'b0;
        end else begin
            if (accept) begin
                wr_addr_q     <= dec_addr;
                wr_bank_sel_q <= dec_bank; // RL5 RL9
                wr_indexed_q  <= dec_idx; // RL6
            end
        end
    end

    // Working byte: loaded in the read quarter, changed in the process quarter
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            result_q <= `BYTE_RST;
        end else begin
            case (q_state_q)
                ST_READ: begin
                    result_q <= rd_data;
                end
                ST_PROCESS: begin
                    if (op_rot_q)
                        result_q <= rot_val; // RL2
                    else if (op_set_q)
                        result_q <= `ALL_ONES; // RL8
                end
                default: begin
                    result_q <= result_q;
                end
            endcase
        end
    end

    // File write in the write quarter
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_en_q   <= 1'b0;
            wr_data_q <= `BYTE_RST;
        end else begin
            wr_en_q <= in_write && dest_q; // RL3
            if (in_write && dest_q) begin
                wr_data_q <= result_q; // RL8
            end
        end
    end

    // Accumulator write in the write quarter
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_wr_q   <= 1'b0;
            acc_data_q <= `BYTE_RST;
        end else begin
            acc_wr_q <= in_write && !dest_q; // RL3
            if (in_write && !dest_q) begin
                acc_data_q <= result_q;
            end
        end
    end

    // Set leaves every flag alone; only a rotate raises the flag strobe
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_wr_q <= 1'b0;
            neg_q     <= 1'b0;
            zero_q    <= 1'b0;
        end else begin
            flag_wr_q <= in_write && op_rot_q; // RL4
            if (in_write && op_rot_q) begin
                neg_q  <= result_q[7]; // RL4
                zero_q <= (result_q == `BYTE_RST); // RL4
            end
        end
    end
endmodule

// file: rot_set_regs.vh
`ifndef ROT_SET_REGS_VH
`define ROT_SET_REGS_VH

// Opcode patterns
`define ROR_OPC_MSB      15
`define ROR_OPC_LSB      10
`define ROR_OPC          6'h10
`define SET_OPC_MSB      15
`define SET_OPC_LSB      9
`define SET_OPC          7'h34
// Field positions
`define FLD_DEST         9
`define FLD_ACC          8
`define FLD_ADDR_MSB     7
`define FLD_ADDR_LSB     0
// Indexed literal-offset limit
`define IDX_LIMIT        8'h5f
// Values
`define ALL_ONES         8'hff
`define BYTE_RST         8'h00
`define WORD_RST         16'h0000
// Quarter cycle states, one-hot
`define Q1_ST            4'h1
`define Q2_ST            4'h2
`define Q3_ST            4'h4
`define Q4_ST            4'h8
`define Q_CYCLES         2'h3

`endif

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic        sys_clk = 1'b0, arst_n = 1'b0, instr_valid = 1'b0, ext_set_en = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic        busy_q, done_q, rd_en_q, rd_bank_sel_q, rd_indexed_q, wr_en_q, wr_bank_sel_q;
    logic        wr_indexed_q, acc_wr_q, flag_wr_q, neg_q, zero_q;
    logic [7:0]  rd_addr_q, rd_data, wr_addr_q, wr_data_q, acc_data_q;
    int          errors = 0, checks_done = 0, cyc = 0;
    logic [16:0] tbl [8] = '{17'h04320, 17'h1405f, 17'h14260, 17'h16810, 17'h06920, 17'h04320, 17'h041d7, 17'h14210};
    rot_set_exec DUT (
        .sys_clk       (sys_clk),
        .arst_n        (arst_n),
        .instr_valid   (instr_valid),
        .instr         (instr),
        .ext_set_en    (ext_set_en),
        .busy_q        (busy_q),
        .done_q        (done_q),
        .rd_en_q       (rd_en_q),
        .rd_addr_q     (rd_addr_q),
        .rd_bank_sel_q (rd_bank_sel_q),
        .rd_indexed_q  (rd_indexed_q),
        .rd_data       (rd_data),
        .wr_en_q       (wr_en_q),
        .wr_addr_q     (wr_addr_q),
        .wr_bank_sel_q (wr_bank_sel_q),
        .wr_indexed_q  (wr_indexed_q),
        .wr_data_q     (wr_data_q),
        .acc_wr_q      (acc_wr_q),
        .acc_data_q    (acc_data_q),
        .flag_wr_q     (flag_wr_q),
        .neg_q         (neg_q),
        .zero_q        (zero_q)
    );
    reg_file_model pm (.sys_clk(sys_clk), .rd_en(rd_en_q), .rd_bank(rd_bank_sel_q), .wr_en(wr_en_q),
        .wr_bank(wr_bank_sel_q), .rd_addr(rd_addr_q), .wr_addr(wr_addr_q), .wr_data(wr_data_q), .rd_data(rd_data));
    initial forever #12.5 sys_clk = ~sys_clk;
    task chk(input logic [7:0] s, e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("ERROR t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Entered at a falling edge; returns in the done cycle so calls run back to back
    task automatic op(input logic [15:0] w, input logic x);
        logic       rot, fil;
        logic [7:0] r;
        rot = w[15:10] == 6'h10;
        fil = !rot || w[9];
        instr_valid = 1'b1;
        instr = w;
        ext_set_en = x;
        @(negedge sys_clk);
        // A second word held while busy must be ignored
        instr = 16'h6800;
        r = rot ? {pm.mem[w[8:0]][0], pm.mem[w[8:0]][7:1]} : 8'hff;
        chk(rd_en_q, 1'b1);
        chk(rd_addr_q, w[7:0]);
        chk(rd_bank_sel_q, w[8]);
        chk(rd_indexed_q, !w[8] && x && w[7:0] <= 8'h5f);
        repeat (2) begin
            @(negedge sys_clk);
            chk(rd_en_q, 1'b0);
        end
        instr_valid = 1'b0;
        @(negedge sys_clk);
        chk(done_q, 1'b1);
        chk(fil ? wr_data_q : acc_data_q, r);
        chk(wr_en_q, fil);
        chk(acc_wr_q, !fil);
        chk(wr_addr_q, w[7:0]);
        chk(wr_bank_sel_q, w[8]);
        chk(wr_indexed_q, !w[8] && x && w[7:0] <= 8'h5f);
        chk(flag_wr_q, rot);
        if (rot) chk({neg_q, zero_q}, {r[7], r == 8'h00});
        $display("op %h done", w);
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            errors++;
            wrap_up;
        end
    end
    initial begin
        repeat (16) @(negedge sys_clk);
        arst_n = 1'b1;
        @(negedge sys_clk);
        for (int i = 0; i < 8; i++) op(tbl[i][15:0], tbl[i][16]);
        // Near-miss opcodes must not start a cycle
        instr_valid = 1'b1;
        for (int k = 0; k < 2; k++) begin
            instr = (k == 0) ? 16'h4400 : 16'h6a00;
            @(negedge sys_clk);
            chk(rd_en_q, 1'b0);
            chk(busy_q, 1'b0);
        end
        instr_valid = 1'b0;
        $display("ignore test done");
        @(negedge sys_clk);
        wrap_up;
    end
endmodule
bind rot_set_exec rot_set_chk chk_i (
    .sys_clk(sys_clk), .arst_n(arst_n), .instr_valid(instr_valid), .ext_set_en(ext_set_en),
    .busy_q(busy_q), .done_q(done_q), .instr(instr), .rd_en_q(rd_en_q), .rd_bank_sel_q(rd_bank_sel_q),
    .rd_indexed_q(rd_indexed_q), .wr_en_q(wr_en_q), .acc_wr_q(acc_wr_q), .flag_wr_q(flag_wr_q),
    .neg_q(neg_q), .zero_q(zero_q), .rd_addr_q(rd_addr_q), .rd_data(rd_data), .wr_data_q(wr_data_q),
    .acc_data_q(acc_data_q)
);
